//--- ssb_pkg.sv
// Shared constants and types of the servo stop and brake sequencer.
// Assumes a single 100 MHz clock and a 16-bit register address port.
package ssb_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = TICK_MS * CLK_MHZ * 1000;
  localparam int PERMIT_US = 10;
  localparam int PERMIT_CYCLES = PERMIT_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] A_DIR_INV = 16'h2006;
  localparam logic [15:0] A_CTRL = 16'h2100;
  localparam logic [15:0] A_MODE = 16'h2101;
  localparam logic [15:0] A_DIS_SEL = 16'h2102;
  localparam logic [15:0] A_ALM_SEL = 16'h2103;
  localparam logic [15:0] A_TORQUE = 16'h2104;
  localparam logic [15:0] A_TIMEOUT = 16'h2105;
  localparam logic [15:0] A_SPD_THR = 16'h2106;
  localparam logic [15:0] A_STATUS = 16'h2110;
  localparam logic [15:0] A_IRQ_ST = 16'h2111;
  localparam logic [15:0] A_IRQ_CLR = 16'h2112;
  localparam logic [15:0] A_IRQ_EN = 16'h2113;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_POL_BIT = 1;
  localparam logic [7:0] RUN_MODE = 8'h08;
  localparam logic [1:0] M_SERVO = 2'h0;
  localparam logic [1:0] M_FREE = 2'h1;
  localparam logic [1:0] M_DYN = 2'h2;
  localparam logic [1:0] AS_DYN = 2'h0;
  localparam logic [1:0] AS_FREE = 2'h1;
  localparam logic [1:0] AS_LOCK = 2'h2;
  localparam logic [3:0] SEL_RST = 4'h0;
  localparam logic [15:0] TORQUE_RST = 16'h0000;
  localparam logic [15:0] TIMEOUT_RST = 16'h0064;
  localparam logic [15:0] SPD_THR_RST = 16'h0010;
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_STOPPED = 1;
  localparam int IRQ_READY = 2;

  typedef enum logic [2:0] {
    S_OFF, S_READY, S_ON_WAIT, S_RUN, S_DECEL, S_STOP
  } ssb_state_t;

endpackage : ssb_pkg

//--- ssb_sequencer.sv
// Servo enable, stop and holding-brake sequencer with register port.
// Assumes pins ALARM, MAIN_POWER and LINK_OP are asynchronous; all
// other inputs come from logic on CLK.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module ssb_sequencer #(
  parameter int TICK_LEN = ssb_pkg::TICK_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [15:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic INIT_DONE,
  input wire logic MAIN_POWER,
  input wire logic LINK_OP,
  input wire logic ALARM,
  input wire logic [15:0] MOTOR_SPEED,
  input wire logic [31:0] CMD_IN,
  output logic [31:0] MOTOR_CMD,
  output logic SERVO_READY,
  output logic SERVO_ON_STATUS,
  output logic CMD_ALLOWED,
  output logic POWER_ON,
  output logic REVERSE_BRAKE,
  output logic [15:0] TORQUE_LIMIT,
  output logic DYN_BRAKE,
  output logic STOP_HOLD_DB,
  output logic BRAKE_RELEASE,
  output logic BRAKE_ENGAGE,
  output logic IRQ
);
  import ssb_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic pwr_s, link_s, alarm_s;

  // Two stages per pin; only the second stage feeds logic
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {ALARM, LINK_OP, MAIN_POWER};
      pin_s2_q <= pin_s1_q;
    end
  end
  assign pwr_s = pin_s2_q[0];
  assign link_s = pin_s2_q[1];
  assign alarm_s = pin_s2_q[2];

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic dir_inv_q, bus_pol_q, en_req_q;
  logic [7:0] mode_q;
  logic [3:0] dis_sel_q, alm_sel_q;
  logic [15:0] torque_q, timeout_q, spd_thr_q;
  logic [2:0] irq_st_q, irq_en_q, irq_set;
  ssb_state_t st_q, st_d;

  // Software-writable settings
  always_ff @(posedge CLK) begin
    if (RESET) begin
      dir_inv_q <= 1'b0;
      bus_pol_q <= 1'b0;
      en_req_q <= 1'b0;
      mode_q <= 8'h00;
      dis_sel_q <= SEL_RST;
      alm_sel_q <= SEL_RST;
      torque_q <= TORQUE_RST;
      timeout_q <= TIMEOUT_RST;
      spd_thr_q <= SPD_THR_RST;
      irq_en_q <= 3'h0;
    end else if (WR) begin
      case (ADDR)
        A_DIR_INV: dir_inv_q <= WDATA[0];
        A_CTRL: begin
          en_req_q <= WDATA[CTRL_EN_BIT];
          bus_pol_q <= WDATA[CTRL_POL_BIT];
        end
        A_MODE: mode_q <= WDATA[7:0];
        A_DIS_SEL: dis_sel_q <= WDATA[3:0];
        A_ALM_SEL: alm_sel_q <= WDATA[3:0];
        A_TORQUE: torque_q <= WDATA[15:0];
        A_TIMEOUT: timeout_q <= WDATA[15:0];
        A_SPD_THR: spd_thr_q <= WDATA[15:0];
        A_IRQ_EN: irq_en_q <= WDATA[2:0];
        default: ;
      endcase
    end
  end

  // Read data valid in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge CLK) begin
    if (RESET) begin
      RDATA <= 32'h0;
    end else if (RD) begin
      case (ADDR)
        A_DIR_INV: RDATA <= {31'h0, dir_inv_q};
        A_CTRL: RDATA <= {30'h0, bus_pol_q, en_req_q};
        A_MODE: RDATA <= {24'h0, mode_q};
        A_DIS_SEL: RDATA <= {28'h0, dis_sel_q};
        A_ALM_SEL: RDATA <= {28'h0, alm_sel_q};
        A_TORQUE: RDATA <= {16'h0, torque_q};
        A_TIMEOUT: RDATA <= {16'h0, timeout_q};
        A_SPD_THR: RDATA <= {16'h0, spd_thr_q};
        A_STATUS: RDATA <= {24'h0, CMD_ALLOWED, SERVO_ON_STATUS, SERVO_READY,
                            BRAKE_RELEASE, 1'b0, st_q};
        A_IRQ_ST: RDATA <= {29'h0, irq_st_q};
        A_IRQ_EN: RDATA <= {29'h0, irq_en_q};
        default: RDATA <= 32'h0;
      endcase
    end else begin
      RDATA <= 32'h0;
    end
  end

  // Sticky events; a new event beats a clear in the same cycle
  always_ff @(posedge CLK) begin
    if (RESET) begin
      irq_st_q <= 3'h0;
    end else if (WR && ADDR == A_IRQ_CLR) begin
      irq_st_q <= (irq_st_q & ~WDATA[2:0]) | irq_set;
    end else begin
      irq_st_q <= irq_st_q | irq_set;
    end
  end

  // Level interrupt, registered
  always_ff @(posedge CLK) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |((irq_st_q | irq_set) & irq_en_q);
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic spd_low, ready_ok, enable_ok, decel_end;
  logic [3:0] sel_q;
  logic [31:0] tick_q;
  logic [15:0] ms_q;
  logic [15:0] permit_q;

  assign spd_low = MOTOR_SPEED < spd_thr_q;
  assign ready_ok = INIT_DONE && pwr_s;
  // Enable only from a settled drive with link up and mode 8
  assign enable_ok = en_req_q && link_s && mode_q == RUN_MODE && spd_low && !alarm_s;
  // First of timeout or low speed ends the deceleration
  assign decel_end = spd_low || ms_q >= timeout_q;

  // Next state; alarm and disable share one stop path
  always_comb begin
    st_d = st_q;
    case (st_q)
      S_OFF: if (ready_ok) st_d = S_READY;
      S_READY: begin
        if (!ready_ok) st_d = S_OFF;
        else if (enable_ok) st_d = S_ON_WAIT;
      end
      S_ON_WAIT: begin
        if (alarm_s || !en_req_q || !pwr_s) st_d = S_DECEL;
        else if (permit_q == PERMIT_CYCLES[15:0]) st_d = S_RUN;
      end
      S_RUN: if (alarm_s || !en_req_q || !pwr_s) st_d = S_DECEL;
      S_DECEL: if (decel_end) st_d = S_STOP;
      S_STOP: if (!alarm_s && !en_req_q) st_d = S_OFF;
      default: st_d = S_OFF;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) st_q <= S_OFF;
    else st_q <= st_d;
  end

  // Latch the selection picked by the cause when a stop begins
  always_ff @(posedge CLK) begin
    if (RESET) begin
      sel_q <= SEL_RST;
    end else if (st_d == S_DECEL && st_q != S_DECEL) begin
      sel_q <= alarm_s ? alm_sel_q : dis_sel_q;
    end
  end

  // Millisecond timebase; restarts at every stop so timeout is exact
  always_ff @(posedge CLK) begin
    if (RESET || st_q != S_DECEL) begin
      tick_q <= 32'h0;
      ms_q <= 16'h0;
    end else if (tick_q == TICK_LEN[31:0] - 32'h1) begin
      tick_q <= 32'h0;
      if (ms_q != 16'hffff) ms_q <= ms_q + 16'h1;
    end else begin
      tick_q <= tick_q + 32'h1;
    end
  end

  // Hold off commands for a while after servo-on is reported
  always_ff @(posedge CLK) begin
    if (RESET || st_q != S_ON_WAIT) permit_q <= 16'h0;
    else if (permit_q != PERMIT_CYCLES[15:0]) permit_q <= permit_q + 16'h1;
  end

  // Events for the interrupt logic
  assign irq_set[IRQ_ALARM] = st_d == S_DECEL && st_q != S_DECEL && alarm_s;
  assign irq_set[IRQ_STOPPED] = st_q == S_DECEL && st_d == S_STOP;
  assign irq_set[IRQ_READY] = st_q == S_OFF && st_d == S_READY;

  // ----------------------------------------------------------------
  // Drive outputs, registered from the next state
  // ----------------------------------------------------------------
  logic inv;
  // Local inversion overrides bus polarity
  assign inv = dir_inv_q ? 1'b1 : bus_pol_q;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      SERVO_READY <= 1'b0;
      SERVO_ON_STATUS <= 1'b0;
      CMD_ALLOWED <= 1'b0;
      MOTOR_CMD <= 32'h0;
    end else begin
      SERVO_READY <= st_d != S_OFF;
      SERVO_ON_STATUS <= st_d == S_ON_WAIT || st_d == S_RUN;
      CMD_ALLOWED <= st_d == S_RUN;
      // Command forced to zero whenever commands are not accepted
      MOTOR_CMD <= st_d != S_RUN ? 32'h0 : (inv ? 32'h0 - CMD_IN : CMD_IN);
    end
  end

  // Power stage per stop method and after-stop state
  always_ff @(posedge CLK) begin
    if (RESET) begin
      POWER_ON <= 1'b0;
      REVERSE_BRAKE <= 1'b0;
      TORQUE_LIMIT <= 16'h0;
      DYN_BRAKE <= 1'b0;
      STOP_HOLD_DB <= 1'b0;
    end else begin
      POWER_ON <= st_d == S_ON_WAIT || st_d == S_RUN ||
                  (st_d == S_DECEL && st_q != S_DECEL ? (alarm_s ? alm_sel_q[1:0] :
                   dis_sel_q[1:0]) == M_SERVO : st_d == S_DECEL && sel_q[1:0] == M_SERVO);
      REVERSE_BRAKE <= st_d == S_DECEL && st_q == S_DECEL && sel_q[1:0] == M_SERVO;
      // Braking torque capped by the stop torque setting
      TORQUE_LIMIT <= (st_d == S_DECEL && st_q == S_DECEL) ? torque_q : 16'h0;
      // Decel-phase dynamic braking dropped at the end
      DYN_BRAKE <= st_d == S_DECEL && st_q == S_DECEL && sel_q[1:0] >= M_DYN;
      STOP_HOLD_DB <= st_d == S_STOP && sel_q[3:2] == AS_DYN;
    end
  end

  // Brake released only while servo is on or decelerating
  always_ff @(posedge CLK) begin
    if (RESET) begin
      BRAKE_RELEASE <= 1'b0;
      BRAKE_ENGAGE <= 1'b1;
    end else begin
      BRAKE_RELEASE <= st_d == S_ON_WAIT || st_d == S_RUN || st_d == S_DECEL;
      BRAKE_ENGAGE <= !(st_d == S_ON_WAIT || st_d == S_RUN || st_d == S_DECEL);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence decel_done_s;
    st_q == S_DECEL ##1 st_q == S_STOP;
  endsequence

  sequence stop_start_s;
    st_q != S_DECEL ##1 st_q == S_DECEL;
  endsequence

  pass_cmd_a: assert property (
    st_d == S_RUN && !dir_inv_q && !bus_pol_q |=> MOTOR_CMD == $past(CMD_IN))
    else $error("command sign changed");
  inv_cmd_a: assert property (
    st_d == S_RUN && dir_inv_q |=> MOTOR_CMD == 32'h0 - $past(CMD_IN))
    else $error("command not inverted");
  pol_pri_a: assert property (
    st_d == S_RUN && !dir_inv_q && bus_pol_q |=> MOTOR_CMD == 32'h0 - $past(CMD_IN))
    else $error("bus polarity ignored");
  ready_gate_a: assert property (
    $rose(SERVO_READY) |-> $past(INIT_DONE) && $past(pwr_s))
    else $error("ready without init or power");
  cmd_hold_a: assert property (
    $rose(SERVO_ON_STATUS) |-> !CMD_ALLOWED [*3])
    else $error("commands allowed too early");
  free_stop_a: assert property (
    st_q == S_DECEL && sel_q[1:0] == M_FREE |-> !POWER_ON && !DYN_BRAKE)
    else $error("coast stop drives motor");
  sel_pick_a: assert property (
    stop_start_s |-> sel_q == ($past(alarm_s) ? $past(alm_sel_q) : $past(dis_sel_q)))
    else $error("wrong stop selection");
  // Limit was registered from the setting one cycle earlier
  torque_cap_a: assert property (
    REVERSE_BRAKE |-> TORQUE_LIMIT == $past(torque_q) && POWER_ON)
    else $error("stop torque not applied");
  decel_exit_a: assert property (
    st_q == S_DECEL && spd_low |=> st_q == S_STOP)
    else $error("decel did not end");
  decel_tmo_a: assert property (
    st_q == S_DECEL && ms_q >= timeout_q |=> st_q == S_STOP)
    else $error("decel timeout ignored");
  brake_end_a: assert property (
    decel_done_s |-> !DYN_BRAKE && BRAKE_ENGAGE && !BRAKE_RELEASE)
    else $error("bad decel end outputs");
  stop_idle_a: assert property (
    st_q == S_STOP |-> !POWER_ON && !REVERSE_BRAKE && !DYN_BRAKE && BRAKE_ENGAGE)
    else $error("motor driven after stop");
  brake_excl_a: assert property (
    BRAKE_RELEASE != BRAKE_ENGAGE)
    else $error("brake outputs agree");
  enable_gate_a: assert property (
    st_q == S_READY ##1 st_q == S_ON_WAIT |-> $past(mode_q) == RUN_MODE && $past(link_s))
    else $error("enabled outside mode 8");

endmodule : ssb_sequencer

//--- ssb_motor_model.sv
// Motor and load seen from the far side of the stop and brake sequencer.
// Assumes the sequencer drive outputs change on the same rising CLK edge.
`timescale 1ns/1ps
module ssb_motor_model (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic LOAD,
  input wire logic [15:0] LOAD_SPEED,
  input wire logic REVERSE_BRAKE,
  input wire logic DYN_BRAKE,
  input wire logic BRAKE_ENGAGE,
  output logic [15:0] SPEED
);
  // Braking sheds one step a cycle; coasting keeps speed so a timeout can show
  always_ff @(posedge CLK) begin
    if (RESET || BRAKE_ENGAGE) begin
      SPEED <= 16'h0000; // Engaged holding brake locks the axis
    end else if (LOAD) begin
      SPEED <= LOAD_SPEED;
    end else if ((REVERSE_BRAKE || DYN_BRAKE) && SPEED != 16'h0000) begin
      SPEED <= SPEED - 16'h0001;
    end
  end
endmodule : ssb_motor_model

//--- test_servo_stop_brake_sequencer.sv
// Self-checking bench for the stop and brake sequencer.
// Assumes the motor model file is compiled first and TICK_LEN may be shortened.
`timescale 1ns/1ps
module test_servo_stop_brake_sequencer;
  import ssb_pkg::*;
  logic CLK = 0, RESET = 1, WR = 0, RD = 0, INIT_DONE = 0, MAIN_POWER = 0;
  logic LINK_OP = 1, ALARM = 0, load = 0;
  logic [15:0] ADDR = 16'h0000, MOTOR_SPEED, TORQUE_LIMIT;
  logic [31:0] WDATA = 32'h0, RDATA, CMD_IN = 32'h0, MOTOR_CMD, d;
  logic SERVO_READY, SERVO_ON_STATUS, CMD_ALLOWED, POWER_ON, REVERSE_BRAKE;
  logic DYN_BRAKE, STOP_HOLD_DB, BRAKE_RELEASE, BRAKE_ENGAGE, IRQ;
  int n_errors = 0, n_tests = 0;
  // ----------------------------------------------------------------
  // Clock, design and far side
  // ----------------------------------------------------------------
  always #5 CLK = ~CLK;
  ssb_sequencer #(.TICK_LEN(10)) dut (.CLK, .RESET, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .INIT_DONE, .MAIN_POWER, .LINK_OP, .ALARM, .MOTOR_SPEED, .CMD_IN, .MOTOR_CMD,
    .SERVO_READY, .SERVO_ON_STATUS, .CMD_ALLOWED, .POWER_ON, .REVERSE_BRAKE,
    .TORQUE_LIMIT, .DYN_BRAKE, .STOP_HOLD_DB, .BRAKE_RELEASE, .BRAKE_ENGAGE, .IRQ);
  ssb_motor_model model (.CLK, .RESET, .LOAD(load), .LOAD_SPEED(16'h00c8), .REVERSE_BRAKE,
    .DYN_BRAKE, .BRAKE_ENGAGE, .SPEED(MOTOR_SPEED));
  // ----------------------------------------------------------------
  // Compare, bus and wait helpers
  // ----------------------------------------------------------------
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_w
  task automatic chk_b(input logic got, input logic exp);
    chk_w({31'h0, got}, {31'h0, exp});
  endtask : chk_b
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask : rd
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    rd(a);
    chk_w(d, exp);
  endtask : rd_chk
  function automatic logic probe(input int sel);
    case (sel)
      0: return SERVO_READY;
      1: return SERVO_ON_STATUS;
      2: return CMD_ALLOWED;
      default: return BRAKE_ENGAGE;
    endcase
  endfunction : probe
  // Bounded wait; n returns the cycles spent
  task automatic wait_for(input int sel, input logic v, input int lim, output int n);
    #1;
    for (n = 0; n < lim && probe(sel) !== v; n++) begin
      @(posedge CLK);
      #1;
    end
    chk_b(probe(sel), v);
  endtask : wait_for
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    int n;
    #1 chk_b(BRAKE_ENGAGE, 1'b1);
    rd_chk(A_DIR_INV, 32'h0);
    rd_chk(A_TIMEOUT, 32'h64);
    rd_chk(A_SPD_THR, 32'h10);
    rd_chk(A_TORQUE, 32'h0);
    rd_chk(16'h2200, 32'h0);
    wr(A_STATUS, 32'hff);
    rd_chk(A_STATUS, 32'h0);
    MAIN_POWER <= 1'b1;
    repeat (10) @(posedge CLK);
    #1 chk_b(SERVO_READY, 1'b0);
    @(posedge CLK);
    INIT_DONE <= 1'b1;
    wait_for(0, 1'b1, 10, n);
  endtask : t_reset
  task automatic t_irq();
    rd_chk(A_IRQ_ST, 32'h4);
    chk_b(IRQ, 1'b0);
    wr(A_IRQ_EN, 32'h4);
    repeat (2) @(posedge CLK);
    #1 chk_b(IRQ, 1'b1);
    wr(A_IRQ_CLR, 32'h4);
    repeat (2) @(posedge CLK);
    #1 chk_b(IRQ, 1'b0);
    rd_chk(A_IRQ_ST, 32'h0);
    wr(A_IRQ_EN, 32'h3);
  endtask : t_irq
  // Enable without operating mode 8 stays ready
  task automatic t_refuse();
    wr(A_CTRL, 32'h1);
    repeat (5) @(posedge CLK);
    rd_chk(A_STATUS, 32'h21);
    wr(A_CTRL, 32'h0);
    wr(A_MODE, 32'h8);
  endtask : t_refuse
  task automatic enable_run();
    int n;
    wr(A_CTRL, 32'h1);
    wait_for(1, 1'b1, 10, n);
    chk_b(CMD_ALLOWED, 1'b0);
    chk_b(BRAKE_RELEASE, 1'b1);
    wait_for(2, 1'b1, 1100, n);
    chk_b(n >= 995, 1'b1);
  endtask : enable_run
  // Inversion beats bus polarity; polarity acts only with inversion 0
  task automatic t_dir();
    logic [2:0] tbl [4] = '{3'b000, 3'b011, 3'b101, 3'b111};
    foreach (tbl[i]) begin
      wr(A_DIR_INV, {31'h0, tbl[i][2]});
      wr(A_CTRL, {30'h0, tbl[i][1], 1'b1});
      CMD_IN <= 32'h1234;
      repeat (2) @(posedge CLK);
      #1 chk_w(MOTOR_CMD, tbl[i][0] ? 32'h0 - 32'h1234 : 32'h1234);
    end
    wr(A_DIR_INV, 32'h0);
    CMD_IN <= 32'h0;
    wr(A_CTRL, 32'h0);
    repeat (10) @(posedge CLK);
  endtask : t_dir
  // The other selection gets different codes to show which one is used
  task automatic run_stop(input logic alarm, input logic [3:0] sel, input logic [15:0] tmo);
    int n;
    logic [1:0] m;
    m = sel[1:0];
    wr(alarm ? A_ALM_SEL : A_DIS_SEL, {28'h0, sel});
    wr(alarm ? A_DIS_SEL : A_ALM_SEL, {28'h0, sel ^ 4'h6});
    wr(A_TIMEOUT, {16'h0, tmo});
    wr(A_TORQUE, 32'h0123);
    enable_run();
    wr(A_IRQ_CLR, 32'h7);
    load <= 1'b1;
    @(posedge CLK);
    load <= 1'b0;
    if (alarm) begin
      ALARM <= 1'b1;
    end else begin
      wr(A_CTRL, 32'h0);
    end
    wait_for(1, 1'b0, 10, n);
    repeat (2) @(posedge CLK);
    #1 chk_b(REVERSE_BRAKE, m == 2'h0);
    // Stop torque stands through every decel; only servo braking uses it
    chk_w({16'h0, TORQUE_LIMIT}, 32'h0123);
    chk_b(DYN_BRAKE, m[1]);
    chk_b(POWER_ON, m == 2'h0);
    chk_b(BRAKE_ENGAGE, 1'b0);
    wait_for(3, 1'b1, 1200, n);
    chk_b(m == 2'h1 ? n > tmo * 10 - 15 && n < tmo * 10 + 15 : n < tmo * 5, 1'b1);
    chk_b(DYN_BRAKE, 1'b0);
    chk_b(BRAKE_RELEASE, 1'b0);
    chk_b(POWER_ON, 1'b0);
    chk_b(STOP_HOLD_DB, sel[3:2] == 2'h0);
    repeat (2) @(posedge CLK);
    #1 chk_b(IRQ, 1'b1);
    rd(A_IRQ_ST);
    chk_w(d & 32'h3, alarm ? 32'h3 : 32'h2);
    wr(A_IRQ_CLR, 32'h7);
    ALARM <= 1'b0;
    wr(A_CTRL, 32'h0);
    repeat (6) @(posedge CLK);
    wait_for(0, 1'b1, 20, n);
  endtask : run_stop
  // ----------------------------------------------------------------
  // Sequence, verdict and watchdog
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    t_reset();
    t_irq();
    t_refuse();
    enable_run();
    t_dir();
    run_stop(1'b0, 4'h0, 16'h0064);
    run_stop(1'b0, 4'ha, 16'h0064);
    run_stop(1'b1, 4'h5, 16'h0005);
    end_of_test();
  end
  // Whole run needs about 4600 cycles; the limit leaves ample slack
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end
endmodule : test_servo_stop_brake_sequencer
